// ### rtl/spd_pkg.sv
package spd_pkg;
	// Clock and timing
	localparam int unsigned SYS_CLK_MHZ       = 250;
	localparam int unsigned DUMP_TIME_MS      = 500;
	localparam int unsigned DUMP_TIME_CYC     = DUMP_TIME_MS * 1000 * SYS_CLK_MHZ;
	// Serial command format
	localparam int unsigned CMD_ADDR_W        = 7;
	localparam logic [6:0]  REG_DUMP_TRIGGER  = 7'h28;
	localparam logic [6:0]  REG_SOFT_RESET    = 7'h3a;
	localparam logic [7:0]  DUMP_TRIGGER_VAL  = 8'h01;
	localparam logic [7:0]  SOFT_RESET_VAL    = 8'h5a;
	localparam logic [7:0]  ID_REG_VAL        = 8'h3c; // Arbitrary identity value
	localparam logic [6:0]  REG_ID            = 7'h00;
	// Frame geometry
	localparam int unsigned ARRAY_SIDE        = 19;
	localparam int unsigned PIXEL_COUNT       = ARRAY_SIDE * ARRAY_SIDE;
	localparam logic [8:0]  LAST_PIXEL        = 9'h168;
	localparam logic [6:0]  BURST_COUNT       = 7'h40;
	localparam logic [1:0]  FRAMES_PER_BURST  = 2'h3;
	localparam logic [1:0]  START_SYMS        = 2'h3;
	localparam logic [1:0]  NIBBLE_SYMS       = 2'h3;
	// Symbols, high-nibble pin in bit 1
	localparam logic [1:0]  SYM_START         = 2'h3;
	localparam logic [1:0]  SYM_BEGIN         = 2'h1;
	localparam logic [1:0]  SYM_END           = 2'h2;
	localparam logic [1:0]  SYM_FRAME_END     = 2'h0;
	// Buffer
	localparam int unsigned FIFO_DEPTH        = 32;
	localparam int unsigned PIX_W             = 8;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
	} spd_pixel_s;

	typedef enum logic [2:0] {
		SPD_IDLE, SPD_START, SPD_BEGIN, SPD_DATA, SPD_END, SPD_FEND, SPD_HOLD
	} spd_dump_e;
endpackage

// ### rtl/spd_fifo.sv
`timescale 1ns/1ps
module spd_fifo #(
	parameter int unsigned WIDTH = 17,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             clr,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic             full;
	logic             empty;

	// Status from pointers
	assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty     = (wp_r == rp_r);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_r[AW-1:0]];

	// Storage write
	always_ff @(posedge sys_clk) begin
		if (in_valid && !full)
			mem[wp_r[AW-1:0]] <= in_data;
	end

	// Pointers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (clr) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && !full)
				wp_r <= wp_r + 1'b1;
			if (out_ready && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule

// ### rtl/spd_port.sv
`timescale 1ns/1ps
module spd_port
	import spd_pkg::*;
#(
	parameter int unsigned DUMP_CYC = DUMP_TIME_CYC
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	input  wire logic                sclk,
	input  wire logic                mosi,
	input  wire logic                cs_b,
	input  wire logic                dump_clk,
	output logic                     miso_out,
	output logic                     miso_oe,
	output logic                     evt_out,
	output logic                     evt_oe,
	output logic                     three_wire,
	input  wire logic                pix_wr,
	input  wire spd_pkg::spd_pixel_s pix_in,
	output logic                     pix_ready
);
	import spd_pkg::*;

	// Input synchronisers
	logic [1:0] sclk_s_r, mosi_s_r, cs_s_r, dclk_s_r;
	logic       sclk_d_r, dclk_d_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_s_r <= 2'h3;  // Idle level of the serial clock
			mosi_s_r <= 2'h0;
			cs_s_r   <= 2'h3;
			dclk_s_r <= 2'h0;
			sclk_d_r <= 1'b1;  // No false edge after reset
			dclk_d_r <= 1'b0;
		end else begin
			sclk_s_r <= {sclk_s_r[0], sclk};
			mosi_s_r <= {mosi_s_r[0], mosi};
			cs_s_r   <= {cs_s_r[0], cs_b};
			dclk_s_r <= {dclk_s_r[0], dump_clk};
			sclk_d_r <= sclk_s_r[1];
			dclk_d_r <= dclk_s_r[1];
		end
	end

	logic cs_hi, sclk_rise, sclk_fall, dclk_fall;
	assign cs_hi     = cs_s_r[1];
	assign sclk_rise = !cs_hi && sclk_s_r[1] && !sclk_d_r;
	assign sclk_fall = !cs_hi && !sclk_s_r[1] && sclk_d_r;
	assign dclk_fall = !dclk_s_r[1] && dclk_d_r;

	// Serial shifter; select high clears its bit count and data phase
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] cmd_r;
	logic       in_data_r;
	logic [7:0] rd_r;
	logic       soft_rst_r, trig_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt_r  <= 4'h0;
			shift_r    <= 8'h00;
			cmd_r      <= 8'h00;
			in_data_r  <= 1'b0;
			soft_rst_r <= 1'b0;
			trig_r     <= 1'b0;
		end else begin
			soft_rst_r <= 1'b0;
			trig_r     <= 1'b0;
			if (cs_hi) begin
				bit_cnt_r <= 4'h0;
				in_data_r <= 1'b0;
			end else if (sclk_rise) begin
				shift_r <= {shift_r[6:0], mosi_s_r[1]};
				if (bit_cnt_r == 4'h7) begin
					bit_cnt_r <= 4'h0;
					if (!in_data_r) begin
						cmd_r     <= {shift_r[6:0], mosi_s_r[1]};
						in_data_r <= 1'b1;
					end else begin
						in_data_r <= 1'b0;
						if (cmd_r[7] && cmd_r[6:0] == REG_SOFT_RESET
						    && {shift_r[6:0], mosi_s_r[1]} == SOFT_RESET_VAL)
							soft_rst_r <= 1'b1;
						if (cmd_r[7] && cmd_r[6:0] == REG_DUMP_TRIGGER
						    && {shift_r[6:0], mosi_s_r[1]} == DUMP_TRIGGER_VAL)
							trig_r <= 1'b1;
					end
				end else begin
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
			end
		end
	end

	// Read data: identity only, shifted out on falling edges
	logic       miso_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_r   <= 8'h00;
			miso_r <= 1'b0;
		end else if (sclk_rise && bit_cnt_r == 4'h7 && !in_data_r) begin
			rd_r <= ({shift_r[6:0], mosi_s_r[1]} == {1'b0, REG_ID})
			        ? ID_REG_VAL : 8'h00;
		end else if (sclk_fall && in_data_r && !cmd_r[7]) begin
			miso_r <= rd_r[7];
			rd_r   <= {rd_r[6:0], 1'b0};
		end
	end

	// Dump state and mode latch
	spd_dump_e  st_r;
	logic       dump_on_r;
	logic [31:0] time_r;
	logic [1:0] sym_r;
	logic [1:0] cnt_r;
	logic [1:0] frame_r;
	logic [6:0] burst_r;
	logic [8:0] addr_r;
	logic [7:0] pix_r;
	logic       rd_pix;
	spd_pixel_s fifo_q;
	logic       fifo_v;

	// Three-wire held from trigger until soft reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			dump_on_r <= 1'b0;
		else if (soft_rst_r)
			dump_on_r <= 1'b0;
		else if (trig_r)
			dump_on_r <= 1'b1;
	end
	assign three_wire = dump_on_r;

	// Dump duration counter
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			time_r <= 32'h0;
		else if (trig_r && !dump_on_r)
			time_r <= 32'(DUMP_CYC);
		else if (soft_rst_r)
			time_r <= 32'h0;
		else if (time_r != 32'h0)
			time_r <= time_r - 32'h1;
	end

	// Pixel buffer between image store and serialiser
	spd_fifo #(.WIDTH($bits(spd_pixel_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.clr       (soft_rst_r),
		.in_data   (pix_in),
		.in_valid  (pix_wr),
		.in_ready  (pix_ready),
		.out_data  (fifo_q),
		.out_valid (fifo_v),
		.out_ready (rd_pix)
	);
	assign rd_pix = dclk_fall && st_r == SPD_BEGIN && fifo_v;

	// Symbol sequencer, one symbol per dump clock fall
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r    <= SPD_IDLE;
			sym_r   <= SYM_FRAME_END;
			cnt_r   <= 2'h0;
			frame_r <= 2'h0;
			burst_r <= 7'h0;
			addr_r  <= 9'h0;
			pix_r   <= 8'h00;
		end else if (soft_rst_r || !dump_on_r) begin
			st_r  <= SPD_IDLE;
			sym_r <= SYM_FRAME_END;
		end else if (st_r == SPD_IDLE) begin
			st_r    <= (time_r != 32'h0) ? SPD_START : SPD_HOLD;
			cnt_r   <= 2'h0;
			frame_r <= 2'h0;
			burst_r <= 7'h0;
			addr_r  <= 9'h0;
		end else if (dclk_fall) begin
			unique case (st_r)
				SPD_START: begin
					sym_r <= SYM_START;
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == START_SYMS)
						st_r <= SPD_BEGIN;
				end
				SPD_BEGIN: begin
					// Wait for the pixel, previous symbol (start or end) held meanwhile
					if (fifo_v) begin
						sym_r <= SYM_BEGIN;
						pix_r <= fifo_q.data;
						st_r  <= SPD_DATA;
						cnt_r <= 2'h0;
					end
				end
				SPD_DATA: begin
					sym_r <= {pix_r[7 - cnt_r], pix_r[3 - cnt_r]};
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == NIBBLE_SYMS)
						st_r <= SPD_END;
				end
				SPD_END: begin
					sym_r <= SYM_END;
					if (addr_r == LAST_PIXEL) begin
						st_r <= SPD_FEND;
					end else begin
						addr_r <= addr_r + 9'h1;
						st_r   <= SPD_BEGIN;
					end
				end
				SPD_FEND: begin
					sym_r  <= SYM_FRAME_END;
					addr_r <= 9'h0;
					cnt_r  <= 2'h0;
					st_r   <= SPD_START;
					if (frame_r == FRAMES_PER_BURST - 2'h1) begin
						frame_r <= 2'h0;
						burst_r <= burst_r + 7'h1;
						if (burst_r == BURST_COUNT - 7'h1 || time_r == 32'h0)
							st_r <= SPD_HOLD;
					end else begin
						frame_r <= frame_r + 2'h1;
					end
				end
				SPD_HOLD: sym_r <= SYM_FRAME_END;
				default:  st_r  <= SPD_HOLD;
			endcase
		end
	end

	// Pin drive: dump owns both pins, else port rules apply
	assign miso_out = dump_on_r ? sym_r[1] : miso_r;
	assign evt_out  = dump_on_r ? sym_r[0] : 1'b0;
	assign miso_oe  = dump_on_r || (!cs_hi && in_data_r && !cmd_r[7]);
	assign evt_oe   = dump_on_r;

	// Frame start symbol lasts four dump clocks, or longer while no pixel is buffered
	a_start_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_START && dclk_fall && cnt_r == START_SYMS && dump_on_r && !soft_rst_r)
		|=> sym_r == SYM_START && st_r == SPD_BEGIN)
		else $error("frame start symbol wrong");
	a_begin_sym: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_BEGIN && dclk_fall && fifo_v && dump_on_r && !soft_rst_r)
		|=> sym_r == SYM_BEGIN && st_r == SPD_DATA)
		else $error("begin symbol missing");
	a_end_sym: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_END && dclk_fall && dump_on_r && !soft_rst_r) |=> sym_r == SYM_END)
		else $error("end symbol missing");
	a_frame_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_FEND && dclk_fall && dump_on_r && !soft_rst_r)
		|=> sym_r == SYM_FRAME_END && addr_r == 9'h0)
		else $error("frame end symbol missing");

	// Pixel address range and order
	a_addr_max: assert property (@(posedge sys_clk) disable iff (!rst_b)
		addr_r <= LAST_PIXEL)
		else $error("pixel address past array");
	a_addr_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_END && dclk_fall && dump_on_r && !soft_rst_r && addr_r != LAST_PIXEL)
		|=> addr_r == $past(addr_r) + 9'h1)
		else $error("pixel address not ascending");

	// Serial port deselect behaviour
	a_tri_state: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(cs_hi && !dump_on_r) |-> !miso_oe)
		else $error("output driven while deselected");
	a_cs_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cs_hi |=> bit_cnt_r == 4'h0 && !in_data_r)
		else $error("port not reset by deselect");

	// Mode latch and symbol pacing
	a_soft_rst: assert property (@(posedge sys_clk) disable iff (!rst_b)
		soft_rst_r |=> !three_wire ##1 st_r == SPD_IDLE)
		else $error("soft reset did not end dump");
	a_three_wire: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(three_wire && !soft_rst_r) |=> three_wire)
		else $error("three-wire dropped without soft reset");
	a_burst_cap: assert property (@(posedge sys_clk) disable iff (!rst_b)
		burst_r <= BURST_COUNT && frame_r < FRAMES_PER_BURST)
		else $error("burst or frame count overrun");
	a_one_sym: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!dclk_fall && st_r != SPD_IDLE && dump_on_r && !soft_rst_r) |=> $stable(sym_r))
		else $error("symbol changed without dump clock");

	// Trigger loads the timer and starts the first frame
	a_trig_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(trig_r && !dump_on_r && !soft_rst_r)
		|=> (three_wire && time_r == 32'(DUMP_CYC)) ##1 st_r == SPD_START)
		else $error("dump did not start on trigger");
	a_no_early_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_HOLD && time_r != 32'h0) |-> burst_r == BURST_COUNT)
		else $error("dump stopped before its time");

	// Pins held low once the bursts are over
	a_hold_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_HOLD && dump_on_r) |-> sym_r == SYM_FRAME_END)
		else $error("pins not low after last burst");

	// Data phase runs its four symbols
	a_data_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r == SPD_DATA && dclk_fall && dump_on_r && !soft_rst_r && cnt_r != NIBBLE_SYMS)
		|=> st_r == SPD_DATA)
		else $error("data phase cut short");

	// Serial input sampled on rising, output moved on falling clock edges
	a_in_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!sclk_rise |=> $stable(shift_r))
		else $error("input shifted without rising edge");
	a_miso_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!sclk_fall |=> $stable(miso_r))
		else $error("read bit moved without falling edge");

	// Dump owns both pins while three-wire
	a_pins_owned: assert property (@(posedge sys_clk) disable iff (!rst_b)
		three_wire |-> miso_oe && evt_oe)
		else $error("dump pins not driven");
endmodule

// ### tb/spd_host_model.sv
`timescale 1ns/1ps
// Host side of the serial port, plus the dump clock source
module spd_host_model (
	output logic      sclk,
	output logic      mosi,
	output logic      cs_b,
	output logic      dump_clk,
	input  wire logic miso_out,
	input  wire logic miso_oe
);
	logic dclk_en = 1'b0;
	// Idle pins: deselected, clock high
	initial begin
		sclk = 1'b1;
		mosi = 1'b0;
		cs_b = 1'b1;
		dump_clk = 1'b0;
	end
	// Dump clock at 48 ns, stands still while disabled
	always begin
		wait (dclk_en);
		#24 dump_clk = ~dump_clk;
	end
	task automatic dclk(input logic on);
		dclk_en = on;
	endtask
	// Shift n bits MSB first at 1 MHz, change on fall, device samples on rise
	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sclk = 1'b0;
			mosi = b[i];
			#500;
			sclk = 1'b1;
			#500;
		end
	endtask
	// Read data taken just before each rising edge; undriven line reads unknown
	task automatic read_byte(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			#500;
			d[i] = miso_oe ? miso_out : 1'bx;
			sclk = 1'b1;
			#500;
		end
	endtask
	// Full write, select held after last edge, gap before next command
	task automatic write_cmd(input logic [6:0] a, input logic [7:0] d);
		cs_b = 1'b0;
		#120;
		send_bits({1'b1, a}, 8);
		send_bits(d, 8);
		#20000;
		cs_b = 1'b1;
		mosi = ~mosi;
		#10000;
	endtask
	// Read with address-to-data wait and post-read gap
	task automatic read_cmd(input logic [6:0] a, output logic [7:0] d);
		cs_b = 1'b0;
		#120;
		send_bits({1'b0, a}, 8);
		#4000;
		read_byte(d);
		#120;
		cs_b = 1'b1;
		mosi = ~mosi;
		#500;
	endtask
	// Write cut short after n bits, or clocked while deselected
	task automatic broken_cmd(input logic [15:0] w, input int n, input logic sel_b);
		cs_b = sel_b;
		#120;
		send_bits(w[15:8], 8);
		send_bits(w[7:0], n - 8);
		cs_b = 1'b1;
		mosi = ~mosi;
		#10000;
	endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
// Pixel dump bench: host model, pixel source, frame decoder
module tb_top;
	import spd_pkg::*;
	logic       sys_clk    = 1'b0;
	logic       rst_b      = 1'b0;
	logic       pix_wr     = 1'b0;
	logic       took       = 1'b0;
	logic       sclk, mosi, cs_b, dump_clk, miso_out, miso_oe;
	logic       evt_out, evt_oe, three_wire, pix_ready;
	logic [8:0] paddr      = 9'h000;
	spd_pixel_s pix_in     = '0;
	int         num_errors = 0;
	int         num_checks = 0;

	spd_port #(.DUMP_CYC(2000)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .mosi(mosi), .cs_b(cs_b),
		.dump_clk(dump_clk), .miso_out(miso_out), .miso_oe(miso_oe), .evt_out(evt_out),
		.evt_oe(evt_oe), .three_wire(three_wire), .pix_wr(pix_wr), .pix_in(pix_in),
		.pix_ready(pix_ready)
	);
	spd_host_model host (
		.sclk(sclk), .mosi(mosi), .cs_b(cs_b), .dump_clk(dump_clk),
		.miso_out(miso_out), .miso_oe(miso_oe)
	);

	// 250 MHz clock
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] pix_val(input logic [8:0] a);
		return a[7:0] ^ {a[8], 7'h2b};
	endfunction

	// Pixel source in address order, stalled by a full buffer
	always @(posedge sys_clk) took <= pix_wr & pix_ready;
	always @(negedge sys_clk) begin
		if (took) paddr = (paddr == LAST_PIXEL) ? 9'h000 : paddr + 9'h001;
		pix_wr = rst_b;
		pix_in = '{addr: paddr, data: pix_val(paddr)};
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Symbol sampled just before the next dump clock fall moves it
	task automatic next_sym(output logic [1:0] s);
		@(negedge dump_clk);
		s = {miso_out, evt_out};
	endtask

	// Decode one frame, counting pixels against their expected addresses
	task automatic get_frame(input int unsigned npix);
		logic [1:0] s;
		logic [7:0] d;
		int         n;
		n = 0;
		next_sym(s);
		while (s !== SYM_START && n < 5000) begin
			n++;
			next_sym(s);
		end
		for (int i = 0; i < 3; i++) begin
			next_sym(s);
			check("start", 8'(s), 8'(SYM_START));
		end
		for (int unsigned a = 0; a < npix; a++) begin
			d = pix_val(9'(a));
			next_sym(s);
			check("begin", 8'(s), 8'(SYM_BEGIN));
			for (int b = 0; b < 4; b++) begin
				next_sym(s);
				check("data", 8'(s), {6'h00, d[7 - b], d[3 - b]});
			end
			next_sym(s);
			check("end", 8'(s), 8'(SYM_END));
		end
		if (npix == PIXEL_COUNT) begin
			next_sym(s);
			check("frame_end", 8'(s), 8'(SYM_FRAME_END));
		end
	endtask

	task automatic t_read_id;
		logic [7:0] d;
		host.read_cmd(REG_ID, d);
		check("id_read", d, ID_REG_VAL);
		check("miso_idle", 8'(miso_oe), 8'h00);
		host.read_cmd(7'h01, d);
		check("other_read", d, 8'h00);
	endtask

	// Buffer filled until it refuses
	task automatic t_fill;
		int n;
		n = 0;
		while (pix_ready !== 1'b0 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		check("fifo_full", 8'(pix_ready), 8'h00);
	endtask

	// Deselected clocks ignored; a cut command leaves the port aligned
	task automatic t_ignore;
		logic [7:0] d;
		host.broken_cmd({1'b1, REG_DUMP_TRIGGER, DUMP_TRIGGER_VAL}, 16, 1'b1);
		check("deselected_wr", 8'(three_wire), 8'h00);
		host.broken_cmd({1'b1, REG_DUMP_TRIGGER, DUMP_TRIGGER_VAL}, 12, 1'b0);
		check("aborted_wr", 8'(three_wire), 8'h00);
		host.read_cmd(REG_ID, d);
		check("after_abort", d, ID_REG_VAL);
	endtask

	// Trigger with decoder running alongside, then the next frame's head
	task automatic t_dump;
		host.dclk(1'b1);
		fork
			host.write_cmd(REG_DUMP_TRIGGER, DUMP_TRIGGER_VAL);
			get_frame(PIXEL_COUNT);
		join
		check("three_wire", 8'(three_wire), 8'h01);
		check("dump_oe", {6'h00, miso_oe, evt_oe}, 8'h03);
		get_frame(3);
	endtask

	// Soft reset ends the dump, then the sequence runs once more
	task automatic t_soft_reset;
		logic [7:0] d;
		host.write_cmd(REG_SOFT_RESET, SOFT_RESET_VAL);
		host.dclk(1'b0);
		check("four_wire", 8'(three_wire), 8'h00);
		check("released", {6'h00, miso_oe, evt_oe}, 8'h00);
		host.read_cmd(REG_ID, d);
		check("id_again", d, ID_REG_VAL);
		host.dclk(1'b1);
		fork
			host.write_cmd(REG_DUMP_TRIGGER, DUMP_TRIGGER_VAL);
			get_frame(0);
		join
		check("redump", 8'(three_wire), 8'h01);
	endtask

	// Reset, then the scenarios in order
	initial begin
		repeat (12) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_read_id();
		t_fill();
		t_ignore();
		t_dump();
		t_soft_reset();
		complete_run();
	end

	// Watchdog beyond the expected run of some 340 us
	initial begin
		#390000;
		num_errors++;
		$display("Error watchdog expected done seen timeout");
		complete_run();
	end
endmodule
